// *** core/cct_pkg.sv ***
/*
  package for the capture/compare timer: register indices, field positions,
  reset values, encodings and the control struct.
  assumes a 32-bit apb slave; byte address is four times the index.
*/
`default_nettype none
package cct_pkg;
  localparam int          ADDR_W        = 18;
  localparam logic [15:0] IDX_CTRL      = 16'hff7e;
  localparam logic [15:0] IDX_EDGE      = 16'hff80;
  localparam logic [15:0] IDX_SAMPLE    = 16'hff81;
  localparam logic [15:0] IDX_COUNT     = 16'hff82;
  localparam logic [15:0] IDX_CC        = 16'hff83;
  localparam logic [15:0] IDX_CONLY     = 16'hff84;
  localparam logic [7:0]  CTRL_RST      = 8'h00;
  localparam logic [7:0]  EDGE_RST      = 8'h00;
  localparam logic [7:0]  SAMPLE_RST    = 8'h00;
  localparam logic [3:0]  EDGE_RW_MASK  = 4'hf;
  localparam int          PRE_W         = 10;
  localparam int          SMP_W         = 6;
  localparam int          FILT_DEPTH    = 4;
  // edge select codes, two bits per input
  localparam logic [1:0]  EDGE_FALL     = 2'h0;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_NONE     = 2'h2;
  localparam logic [1:0]  EDGE_BOTH     = 2'h3;
  // sample clock divide, log2, per sample_clock_reg[1:0] code
  localparam int          SMP_LOG2_0    = 0;
  localparam int          SMP_LOG2_1    = 2;
  localparam int          SMP_LOG2_2    = 4;
  localparam int          SMP_LOG2_3    = 6;
  // count clock divide, log2, per count_clock_select code (code 5 is a parameter)
  localparam int          DIV_LOG2_0    = 2;
  localparam int          DIV_LOG2_1    = 3;
  localparam int          DIV_LOG2_2    = 4;
  localparam int          DIV_LOG2_3    = 5;
  localparam int          DIV_LOG2_4    = 6;
  localparam int          DIV_LOG2_5    = 8;
  localparam int          DIV_LOG2_6    = 9;
  localparam int          DIV_LOG2_7    = 10;

  typedef struct packed {
    logic       count_enable_bit;
    logic [1:0] zero_bits;
    logic       compare_select_bit;
    logic       interval_clear_bit;
    logic [2:0] count_clock_select;
  } cct_ctrl_s;
endpackage
`default_nettype wire

// *** core/cct_noise_filter.sv ***
/*
  four-sample noise filter for one external input.
  assumes the input is synchronous to pclk and sample_en is a one-cycle pulse.
*/
`default_nettype none
module cct_noise_filter
  import cct_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sample_en,
  input  wire logic din,
  output logic      level_ff
);
  logic [FILT_DEPTH-1:0] shift_ff;
  logic                  all_one;
  logic                  all_zero;

  assign all_one  = &shift_ff;
  assign all_zero = ~|shift_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_ff <= '0;
    end else if (sample_en) begin
      shift_ff <= {shift_ff[FILT_DEPTH-2:0], din};
    end
  end

  // new level only when four samples agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_ff <= 1'b0;
    end else if (all_one) begin
      level_ff <= 1'b1;
    end else if (all_zero) begin
      level_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_level_agree: assert property ($changed(level_ff) |-> $past(all_one || all_zero))
    else $error("filter level changed without four agreeing samples");
  a_short_pulse: assert property ((!level_ff && all_zero) ##1 (!all_one) |=> !level_ff)
    else $error("filter accepted a level before four samples agreed");
endmodule // cct_noise_filter
`default_nettype wire

// *** core/cct_timer.sv ***
/*
  16-bit capture/compare timer with apb register access.
  assumes inputs synchronous to pclk; apb master holds requests until pready.
*/
// Behaviour
// - 16-bit up-counter on divided system clock
// - reset clears counter and stops it
// - capture mode latches count on capture edge
// - capture-only register latches count on edge
// - compare mode flags match when values equal
// - three-bit select picks eight clock divisions
// - mode bits pick free-running or interval behaviour
// - enable low stops and holds count zero
// - first count clock holds zero, second advances
// - rewriting enable does not disturb counting
// - held match clears counter on next tick
// - interval capture clears counter on edge
// - free-running count wraps after all ones
// - compare mode blocks external capture interrupt
// - writes hit compare, reads follow mode
// - control register layout, resets to zero
// - control bits six and five read zero
// - edge register picks valid edges, low nibble
// - filter accepts level after four agreeing samples
// - sample clock register picks sampling rate
// - match and capture share one vector
`default_nettype none
module cct_timer
  import cct_pkg::*;
#(
  parameter int DIV5_LOG2 = DIV_LOG2_5
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [cct_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]          pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 ext_capture_input,
  input  wire logic                 second_edge_input,
  output logic                      compare_match_irq,
  output logic                      ext_capture_irq,
  output logic                      second_edge_irq,
  output logic                      shared_vector_irq
);
  import cct_pkg::*;

  if (DIV5_LOG2 < 1 || DIV5_LOG2 > PRE_W) begin : g_bad_div
    $error("DIV5_LOG2 out of range");
  end

  cct_ctrl_s         ctrl_ff;
  logic [3:0]        edge_ff;
  logic [7:0]        sample_ff;
  logic [15:0]       count_ff;
  logic [15:0]       cmp_ff;
  logic [15:0]       cap_ff;
  logic [15:0]       conly_ff;
  logic              started_ff;
  logic              pending_ff;
  logic              match_prev_ff;
  logic [PRE_W-1:0]  pre_ff;
  logic [SMP_W-1:0]  smp_ff;
  logic              ext_prev_ff;
  logic              sec_prev_ff;
  logic              ready_ff;
  logic [31:0]       rdata_ff;
  logic              err_ff;
  logic              cmp_irq_ff;
  logic              ext_irq_ff;
  logic              sec_irq_ff;
  logic              vec_irq_ff;

  logic              en;
  logic              cmp_sel;
  logic              clr_sel;
  logic [PRE_W-1:0]  div_mask;
  logic [SMP_W-1:0]  smp_mask;
  logic              tick;
  logic              sample_en;
  logic              ext_lvl;
  logic              sec_lvl;
  logic              ext_valid;
  logic              sec_valid;
  logic              cap_clear;
  logic              match_now;
  logic              match_pulse;
  logic              acc;
  logic              wr;
  logic [15:0]       idx;
  logic              hit;
  logic [31:0]       nxt_rdata;

  assign en      = ctrl_ff.count_enable_bit;
  assign cmp_sel = ctrl_ff.compare_select_bit;
  assign clr_sel = ctrl_ff.interval_clear_bit;

  // count clock division
  function automatic logic [PRE_W-1:0] lmask(input int n);
    lmask = PRE_W'((1 << n) - 1);
  endfunction

  always_comb begin
    case (ctrl_ff.count_clock_select)
      3'h0:    div_mask = lmask(DIV_LOG2_0);
      3'h1:    div_mask = lmask(DIV_LOG2_1);
      3'h2:    div_mask = lmask(DIV_LOG2_2);
      3'h3:    div_mask = lmask(DIV_LOG2_3);
      3'h4:    div_mask = lmask(DIV_LOG2_4);
      3'h5:    div_mask = lmask(DIV5_LOG2);
      3'h6:    div_mask = lmask(DIV_LOG2_6);
      3'h7:    div_mask = lmask(DIV_LOG2_7);
      default: div_mask = lmask(DIV_LOG2_0);
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= '0;
    end else if (!en) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + PRE_W'(1);
    end
  end

  assign tick = en && ((pre_ff & div_mask) == div_mask);

  // sampling clock for the filters
  always_comb begin
    case (sample_ff[1:0])
      2'h0:    smp_mask = SMP_W'((1 << SMP_LOG2_0) - 1);
      2'h1:    smp_mask = SMP_W'((1 << SMP_LOG2_1) - 1);
      2'h2:    smp_mask = SMP_W'((1 << SMP_LOG2_2) - 1);
      2'h3:    smp_mask = SMP_W'((1 << SMP_LOG2_3) - 1);
      default: smp_mask = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_ff <= '0;
    end else begin
      smp_ff <= smp_ff + SMP_W'(1);
    end
  end

  assign sample_en = ((smp_ff & smp_mask) == smp_mask);

  cct_noise_filter u_ext_filt (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (sample_en),
    .din       (ext_capture_input),
    .level_ff  (ext_lvl)
  );

  cct_noise_filter u_sec_filt (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (sample_en),
    .din       (second_edge_input),
    .level_ff  (sec_lvl)
  );

  // edge detection on filtered levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_prev_ff <= 1'b0;
      sec_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_lvl;
      sec_prev_ff <= sec_lvl;
    end
  end

  function automatic logic edge_ok(input logic [1:0] code, input logic now, input logic prev);
    case (code)
      EDGE_FALL: edge_ok = prev && !now;
      EDGE_RISE: edge_ok = !prev && now;
      EDGE_BOTH: edge_ok = prev != now;
      EDGE_NONE: edge_ok = 1'b0;
      default:   edge_ok = 1'b0;
    endcase
  endfunction

  assign ext_valid = edge_ok(edge_ff[1:0], ext_lvl, ext_prev_ff);
  assign sec_valid = edge_ok(edge_ff[3:2], sec_lvl, sec_prev_ff);
  assign cap_clear = en && ext_valid && !cmp_sel && clr_sel;

  // counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      started_ff <= 1'b0;
    end else if (!en) begin
      started_ff <= 1'b0;
    end else if (tick) begin
      started_ff <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_ff <= '0;
    end else if (!en) begin
      count_ff <= '0;
    end else if (cap_clear) begin
      count_ff <= '0;
    end else if (tick) begin
      if (!started_ff) begin
        count_ff <= count_ff;
      end else if (pending_ff && cmp_sel && clr_sel) begin
        count_ff <= '0;
      end else begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end

  // compare
  assign match_now   = en && cmp_sel && started_ff && (count_ff == cmp_ff);
  assign match_pulse = match_now && !match_prev_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_prev_ff <= 1'b0;
    end else begin
      match_prev_ff <= match_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending_ff <= 1'b0;
    end else if (!en) begin
      pending_ff <= 1'b0;
    end else if (match_pulse) begin
      pending_ff <= 1'b1;
    end else if (tick) begin
      pending_ff <= 1'b0;
    end
  end

  // capture registers, contents undefined after reset
  always_ff @(posedge pclk) begin
    if (ext_valid && !cmp_sel) begin
      cap_ff <= count_ff;
    end
  end

  always_ff @(posedge pclk) begin
    if (ext_valid) begin
      conly_ff <= count_ff;
    end
  end

  // interrupt requests
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_irq_ff <= 1'b0;
      ext_irq_ff <= 1'b0;
      sec_irq_ff <= 1'b0;
      vec_irq_ff <= 1'b0;
    end else begin
      cmp_irq_ff <= match_pulse;
      ext_irq_ff <= ext_valid && !cmp_sel;
      sec_irq_ff <= sec_valid;
      vec_irq_ff <= match_pulse || (ext_valid && !cmp_sel);
    end
  end

  // apb slave, one wait state
  assign acc = psel && penable;
  assign wr  = acc && ready_ff && pwrite;
  assign idx = paddr[ADDR_W-1:2];
  assign hit = (paddr[1:0] == 2'h0) &&
               (idx == IDX_CTRL || idx == IDX_EDGE || idx == IDX_SAMPLE ||
                idx == IDX_COUNT || idx == IDX_CC || idx == IDX_CONLY);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff   <= CTRL_RST;
      edge_ff   <= EDGE_RST[3:0];
      sample_ff <= SAMPLE_RST;
    end else if (wr && pstrb[0] && paddr[1:0] == 2'h0) begin
      if (idx == IDX_CTRL) begin
        ctrl_ff           <= pwdata[7:0];
        ctrl_ff.zero_bits <= 2'h0;
      end
      if (idx == IDX_EDGE) begin
        edge_ff <= pwdata[3:0] & EDGE_RW_MASK;
      end
      if (idx == IDX_SAMPLE) begin
        sample_ff <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (wr && paddr[1:0] == 2'h0 && idx == IDX_CC) begin
      if (pstrb[0]) begin
        cmp_ff[7:0] <= pwdata[7:0];
      end
      if (pstrb[1]) begin
        cmp_ff[15:8] <= pwdata[15:8];
      end
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (idx)
      IDX_CTRL:   nxt_rdata = {24'h0, ctrl_ff};
      IDX_EDGE:   nxt_rdata = {28'h0, edge_ff};
      IDX_SAMPLE: nxt_rdata = {24'h0, sample_ff};
      IDX_COUNT:  nxt_rdata = {16'h0, count_ff};
      IDX_CC:     nxt_rdata = {16'h0, cmp_sel ? cmp_ff : cap_ff};
      IDX_CONLY:  nxt_rdata = {16'h0, conly_ff};
      default:    nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      err_ff   <= 1'b0;
    end else if (acc && !ready_ff) begin
      ready_ff <= 1'b1;
      rdata_ff <= (hit && !pwrite) ? nxt_rdata : 32'h0000_0000;
      err_ff   <= !hit;
    end else begin
      ready_ff <= 1'b0;
      err_ff   <= 1'b0;
    end
  end

  assign prdata            = rdata_ff;
  assign pready            = ready_ff;
  assign pslverr           = err_ff;
  assign compare_match_irq = cmp_irq_ff;
  assign ext_capture_irq   = ext_irq_ff;
  assign second_edge_irq   = sec_irq_ff;
  assign shared_vector_irq = vec_irq_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_disable_zero: assert property ($fell(en) |=> count_ff == 16'h0000 ##1 count_ff == 16'h0000)
    else $error("counter not zero while disabled");
  a_first_tick: assert property (tick && !started_ff && !cap_clear |=> count_ff == 16'h0000 && started_ff)
    else $error("first count clock moved the counter");
  a_count_step: assert property (tick && started_ff && !cap_clear && !(pending_ff && cmp_sel && clr_sel)
                                 |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("counter did not advance by one");
  a_match_clear: assert property (tick && pending_ff && cmp_sel && clr_sel && !cap_clear
                                  |=> count_ff == 16'h0000)
    else $error("held match did not clear counter");
  a_cap_clear: assert property (cap_clear |=> count_ff == 16'h0000)
    else $error("capture edge did not clear counter");
  a_cap_latch: assert property (ext_valid && !cmp_sel |=> cap_ff == $past(count_ff))
    else $error("capture register missed the count");
  a_only_latch: assert property (ext_valid |=> conly_ff == $past(count_ff))
    else $error("capture-only register missed the count");
  a_match_irq: assert property (match_pulse |=> compare_match_irq && shared_vector_irq)
    else $error("match did not raise compare interrupt");
  a_no_ext_irq: assert property (cmp_sel |=> !ext_capture_irq)
    else $error("capture interrupt raised in compare mode");
  a_ctrl_zero: assert property (ctrl_ff.zero_bits == 2'h0 ##1 ctrl_ff.zero_bits == 2'h0)
    else $error("control bits six or five set");
  a_wrap: assert property (tick && started_ff && count_ff == 16'hffff && !cap_clear && !pending_ff
                           |=> count_ff == 16'h0000)
    else $error("counter did not wrap");
endmodule // cct_timer
`default_nettype wire

// *** bench/cct_pin_model.sv ***
/*
  behavioural source for the timer's filtered trigger pins.
  assumes fire is a one-cycle pulse on pclk; the pin idles low.
*/
`default_nettype none
module cct_pin_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fire,
  input  wire logic [7:0] width,
  output logic            pin_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_ff;
  // high for width cycles; below four only when the bench asks for it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left_ff <= 8'h00;
      pin_ff  <= 1'b0;
    end else if (fire) begin
      left_ff <= width;
      pin_ff  <= 1'b1;
    end else if (left_ff > 8'h01) begin
      left_ff <= left_ff - 8'h01;
    end else begin
      left_ff <= 8'h00;
      pin_ff  <= 1'b0;
    end
  end
endmodule // cct_pin_model
`default_nettype wire

// *** bench/capture_compare_timer_test.sv ***
/*
  self-checking bench for the capture/compare timer.
  assumes the timer and pin models are compiled first.
*/
`default_nettype none
module capture_compare_timer_test import cct_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV5 = 8;
  localparam int LG[8] = '{DIV_LOG2_0, DIV_LOG2_1, DIV_LOG2_2, DIV_LOG2_3,
                           DIV_LOG2_4, DIV5, DIV_LOG2_6, DIV_LOG2_7};
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rd, cap;
  logic [3:0]        pstrb, irqs;
  logic              ext_pin, second_pin, fire_ext, fire_second;
  logic              compare_match_irq, ext_capture_irq, second_edge_irq, shared_vector_irq;
  logic [7:0]        width;
  int                n_mismatch, total_checks, n_ext, n_sec, e0, s0, n, cmp, seed;
  time               t0;

  assign irqs = {shared_vector_irq, second_edge_irq, ext_capture_irq, compare_match_irq};
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    if (ext_capture_irq === 1'b1) n_ext++;
    if (second_edge_irq === 1'b1) n_sec++;
  end

  cct_timer #(.DIV5_LOG2(DIV5)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_capture_input(ext_pin), .second_edge_input(second_pin),
    .compare_match_irq(compare_match_irq), .ext_capture_irq(ext_capture_irq),
    .second_edge_irq(second_edge_irq), .shared_vector_irq(shared_vector_irq)
  );
  cct_pin_model u_ext (.pclk(pclk), .presetn(presetn), .fire(fire_ext), .width(width), .pin_ff(ext_pin));
  cct_pin_model u_sec (.pclk(pclk), .presetn(presetn), .fire(fire_second), .width(width), .pin_ff(second_pin));

  function automatic int div_of(input int c);
    return 1 << LG[c];
  endfunction

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_mismatch++;
      final_report();
    end
    rd = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_irq(input int b, input int lim, input bit must);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (irqs[b] !== 1'b1 && n < lim);
    if (must && n >= lim) begin
      n_mismatch++;
      final_report();
    end
  endtask

  task automatic fire(input logic [1:0] m, input logic [7:0] w);
    @(posedge pclk);
    width       <= w;
    fire_ext    <= m[0];
    fire_second <= m[1];
    @(posedge pclk);
    fire_ext    <= 1'b0;
    fire_second <= 1'b0;
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    n_mismatch++;
    final_report();
  end

  initial begin
    seed = 32'h6de29269;
    n_mismatch = 0;
    total_checks = 0;
    n_ext = 0;
    n_sec = 0;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    width = 8'h06;
    fire_ext = 1'b0;
    fire_second = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, IDX_CTRL, 0);    chk(rd, {24'h0, CTRL_RST});
    apb(0, IDX_EDGE, 0);    chk(rd, {24'h0, EDGE_RST});
    apb(0, IDX_SAMPLE, 0);  chk(rd, {24'h0, SAMPLE_RST});
    apb(0, IDX_COUNT, 0);   chk(rd, 32'h0);
    apb(0, 16'h0001, 0);
    chk({31'h0, perr}, 32'h1);
    chk(rd, 32'h0);
    apb(1, IDX_CTRL, 32'h67);
    apb(0, IDX_CTRL, 0);    chk(rd, 32'h07);
    apb(1, IDX_CTRL, 0);
    apb(1, IDX_EDGE, 32'hff);
    apb(0, IDX_EDGE, 0);    chk(rd, 32'h0f);
    apb(1, IDX_SAMPLE, 32'ha4);
    apb(0, IDX_SAMPLE, 0);  chk(rd, 32'ha4);
    apb(1, IDX_EDGE, {28'h0, EDGE_RISE, EDGE_RISE});
    // every clock select, random compare value, free-running compare
    for (int c = 0; c < 8; c++) begin
      cmp = 1 + ($unsigned($random(seed)) % 3);
      apb(1, IDX_CC, 32'(cmp));
      apb(1, IDX_CTRL, 32'h90 | 32'(c));
      wait_irq(0, 4 * div_of(c) + 8, 1);
      chk({31'h0, n >= (cmp + 1) * div_of(c) && n <= (cmp + 1) * div_of(c) + 3}, 32'h1);
      apb(1, IDX_CTRL, 0);
    end
    // interval compare period and enable rewrite
    apb(1, IDX_CC, 32'h3);
    apb(1, IDX_CTRL, 32'h98);
    apb(0, IDX_CC, 0);      chk(rd, 32'h3);
    wait_irq(0, 40, 1);
    t0 = $time;
    wait_irq(0, 40, 1);
    chk(32'(($time - t0) / 8), 32'd16);
    chk({31'h0, shared_vector_irq}, 32'h1);
    t0 = $time;
    apb(1, IDX_CTRL, 32'h98);
    wait_irq(0, 40, 1);
    chk(32'(($time - t0) / 8), 32'd16);
    apb(1, IDX_CTRL, 0);
    apb(0, IDX_COUNT, 0);   chk(rd, 32'h0);
    // free-running capture on a clean pulse
    apb(1, IDX_CTRL, 32'h80);
    repeat (40) @(posedge pclk);
    fire(2'b01, 8'h06);
    wait_irq(1, 30, 1);
    chk({31'h0, shared_vector_irq}, 32'h1);
    apb(0, IDX_CC, 0);
    cap = rd;
    chk({31'h0, cap != 32'h0}, 32'h1);
    apb(0, IDX_CONLY, 0);   chk(rd, cap);
    // a short pulse is filtered away
    fire(2'b01, 8'h02);
    wait_irq(1, 30, 0);
    chk(32'(n), 32'd30);
    // interval capture clears the count
    apb(1, IDX_CTRL, 0);
    apb(1, IDX_CTRL, 32'h88);
    repeat (60) @(posedge pclk);
    fire(2'b01, 8'h06);
    wait_irq(1, 30, 1);
    apb(0, IDX_COUNT, 0);
    chk({31'h0, rd < 32'h3}, 32'h1);
    // compare mode masks the capture interrupt, second pin still works
    apb(1, IDX_CTRL, 0);
    apb(1, IDX_CTRL, 32'h90);
    e0 = n_ext;
    fire(2'b11, 8'h06);
    wait_irq(2, 30, 1);
    repeat (4) @(posedge pclk);
    chk(32'(n_ext - e0), 32'h0);
    apb(1, IDX_CTRL, 0);
    // falling and both edges at the slower sample rate, then no edge at all
    apb(1, IDX_SAMPLE, 32'h01);
    apb(1, IDX_EDGE, {28'h0, EDGE_BOTH, EDGE_FALL});
    apb(1, IDX_CTRL, 32'h80);
    e0 = n_ext;
    s0 = n_sec;
    fire(2'b11, 8'h18);
    repeat (100) @(posedge pclk);
    chk(32'(n_ext - e0), 32'h1);
    chk(32'(n_sec - s0), 32'h2);
    fire(2'b11, 8'h08);
    repeat (60) @(posedge pclk);
    chk(32'(n_sec - s0), 32'h2);
    apb(1, IDX_EDGE, {28'h0, EDGE_NONE, EDGE_NONE});
    fire(2'b11, 8'h18);
    repeat (100) @(posedge pclk);
    chk(32'(n_ext - e0 + n_sec - s0), 32'h3);
    apb(1, IDX_CTRL, 0);
    final_report();
  end
endmodule // capture_compare_timer_test
`default_nettype wire
